// ---- inc/hspp_pkg.sv ----
// Shared constants of the host serial/parallel port: frame layout,
// mode codes, pin reset levels and link timing.
// Assumes a 100 MHz system clock on both ends.
package hspp_pkg;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int BUS_W = 8;
  localparam int CNT_W = 5;
  localparam int FRAME_BITS = 24;
  localparam int HDR_BITS = 8;
  localparam int ADDR_FIRST = 2;
  localparam int LOAD_EDGE = 9;
  localparam int FAST_BITS = 25;
  localparam int SAMP_FIRST = 10;
  localparam logic [1:0] MODE_SER = 2'h0;
  localparam logic [1:0] MODE_P1 = 2'h1;
  localparam logic [1:0] MODE_P2 = 2'h2;
  localparam logic [1:0] MODE_P3 = 2'h3;
  // {cs_n, wr_n, rd_n, ale, sel_hi, sel_lo} while idle
  localparam logic [5:0] PIN_IDLE = 6'h38;
  localparam logic [1:0] STRAP_DONE = 2'h3;
  localparam logic [1:0] STRAP_TAKE = 2'h2;
  localparam int SYS_NS = 10;
  localparam int SCLK_MAX_MHZ = 40;
  localparam int SCLK_FAST_MHZ = 25;
  // Half period of the host-made link clock, least time
  localparam int LINK_HALF_NS = 80;
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + SYS_NS - 1) / SYS_NS;
endpackage

// ---- inc/hspp_link_if.sv ----
// Pins between the host and the device end of the port.
// Assumes the bus has a weak pull-up; both ends never drive together.
`timescale 1ns/100ps
interface hspp_link_if;
  import hspp_pkg::*;
  logic cs_n;
  logic wr_n;
  logic rd_n;
  logic ale;
  logic iface_sel_hi;
  logic iface_sel_lo;
  logic [BUS_W-1:0] dev_out;
  logic [BUS_W-1:0] dev_oe;
  logic [BUS_W-1:0] host_out;
  logic [BUS_W-1:0] host_oe;
  logic [BUS_W-1:0] bus;
  // Wire level: driven bits win, undriven bits pull high
  assign bus = (dev_out & dev_oe) | (host_out & host_oe) |
               ~(dev_oe | host_oe);
  modport dev (
    input cs_n, wr_n, rd_n, ale, iface_sel_hi, iface_sel_lo, bus,
    output dev_out, dev_oe
  );
  modport host (
    output cs_n, wr_n, rd_n, ale, iface_sel_hi, iface_sel_lo,
    output host_out, host_oe,
    input bus
  );
endinterface

// ---- rtl/hspp_dev.sv ----
// Device end of the host port: serial frame engine and three
// multiplexed parallel modes in front of a 128-word register map.
// Assumes the map answers i_reg_rdata combinationally for o_reg_addr.
// Behaviour
// - mode pins 00 serial, 01/10/11 parallel
// - serial: cs frame, wr clock, rd in
// - parallel: 8-bit muxed bus, ale role per mode
// - serial runs from host clock edges only
// - cs high resets serial, keeps addr/data
// - sample on falling, update on rising
// - frame: direction, 7 address, 16 data
// - first bit one reads, zero writes
// - address MSB fall 2, LSB fall 8
// - fetch addressed word at fall 8
// - load word rising 9, shift each rising
// - fall 24 last bit, write strobe if write
// - address increments per word, wraps 7Fh
// - early frame end discards the word
// - slow host samples on following fall
// - fast host samples rising, 25 clocks
// - parallel pointer increments per word (every second strobe)
// - mode one: write on wr rise, cs low
`timescale 1ns/100ps
module hspp_dev (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Asynchronous reset, high
  hspp_link_if.dev link, // Host pins
  output logic [hspp_pkg::ADDR_W-1:0] o_reg_addr, // Map address
  output logic [hspp_pkg::DATA_W-1:0] o_reg_wdata, // Map write data
  output logic o_reg_we, // Map write strobe
  input wire logic [hspp_pkg::DATA_W-1:0] i_reg_rdata, // Map read data
  output logic [1:0] o_mode // Selected mode
);
  import hspp_pkg::*;

  logic [5:0] s1_ff;
  logic [5:0] s2_ff;
  logic [5:0] d_ff;
  logic [BUS_W-1:0] b1_ff;
  logic [BUS_W-1:0] b2_ff;
  logic [1:0] strap_ff;
  logic [1:0] mode_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic dir_ff;
  logic [DATA_W-1:0] rx_ff;
  logic [DATA_W-1:0] tx_ff;
  logic [DATA_W-1:0] hold_ff;
  logic [DATA_W-1:0] wdata_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [BUS_W-1:0] lo_ff;
  logic [BUS_W-1:0] out_ff;
  logic hi_ff;
  logic we_ff;
  logic inc_ff;
  logic fetch_ff;

  // Pin synchronisers; logic reads the second stage, and d_ff for edges
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      s1_ff <= PIN_IDLE;
      s2_ff <= PIN_IDLE;
      d_ff <= PIN_IDLE;
      b1_ff <= '1;
      b2_ff <= '1;
    end else begin
      s1_ff <= {link.cs_n, link.wr_n, link.rd_n, link.ale,
                link.iface_sel_hi, link.iface_sel_lo};
      s2_ff <= s1_ff;
      d_ff <= s2_ff;
      b1_ff <= link.bus;
      b2_ff <= b1_ff;
    end
  end

  wire cs_n = s2_ff[5];
  wire wr = s2_ff[4];
  wire rd = s2_ff[3];
  wire ale = s2_ff[2];
  wire rise_wr = wr & ~d_ff[4];
  wire fall_wr = ~wr & d_ff[4];
  wire rise_rd = rd & ~d_ff[3];
  wire rise_ale = ale & ~d_ff[2];
  wire fall_ale = ~ale & d_ff[2];

  // Mode pins caught once the synchroniser holds their level
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      strap_ff <= '0;
      mode_ff <= MODE_SER;
    end else if (strap_ff != STRAP_DONE) begin
      strap_ff <= strap_ff + 2'h1;
      if (strap_ff == STRAP_TAKE) begin
        mode_ff <= s2_ff[1:0];
      end
    end
  end

  wire ready = strap_ff == STRAP_DONE;
  wire ser_act = ready && mode_ff == MODE_SER && !cs_n;
  wire s_fall = ser_act && fall_wr;
  wire s_rise = ser_act && rise_wr;
  wire sdi = rd;
  wire [CNT_W-1:0] cnt_nx = cnt_ff + CNT_W'(1);
  wire s_dir = s_fall && cnt_nx == CNT_W'(1);
  wire s_abit = s_fall && cnt_nx >= CNT_W'(ADDR_FIRST) &&
                cnt_nx <= CNT_W'(HDR_BITS);
  wire s_fetch = s_fall && cnt_nx == CNT_W'(HDR_BITS);
  wire s_dbit = s_fall && cnt_nx > CNT_W'(HDR_BITS);
  wire s_end = s_fall && cnt_nx == CNT_W'(FRAME_BITS);

  // Parallel strobes per mode
  wire par = ready && mode_ff != MODE_SER && !cs_n;
  wire m1 = mode_ff == MODE_P1;
  wire m3 = mode_ff == MODE_P3;
  wire p_addr_ev = m1 ? (rise_wr && ale) :
                   (m3 ? rise_ale : fall_ale);
  wire p_addr = par && p_addr_ev;
  wire p_wr_ev = m3 ? (rise_rd && !wr) : (rise_wr && !(m1 && ale));
  wire p_wr = par && p_wr_ev;
  wire p_rd = par && rise_rd && (m3 ? wr : 1'b1);
  wire p_word = (p_wr || p_rd) && hi_ff;
  wire p_drive = par && !rd && (m3 ? wr : 1'b1);

  // Frame position and direction, cleared while the frame is idle
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      cnt_ff <= '0;
      dir_ff <= 1'b0;
    end else if (!ser_act) begin
      cnt_ff <= '0;
      dir_ff <= 1'b0;
    end else if (s_fall) begin
      if (s_end) begin
        cnt_ff <= CNT_W'(HDR_BITS);
      end else begin
        cnt_ff <= cnt_nx;
      end
      if (s_dir) begin
        dir_ff <= sdi;
      end
    end
  end

  // Address pointer shared by both protocols
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      addr_ff <= '0;
    end else if (s_abit) begin
      addr_ff <= {addr_ff[ADDR_W-2:0], sdi};
    end else if (p_addr) begin
      addr_ff <= b2_ff[ADDR_W-1:0];
    end else if (inc_ff) begin
      addr_ff <= addr_ff + ADDR_W'(1);
    end
  end

  // Word received and write strobe; an unfinished frame never writes
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      rx_ff <= '0;
      wdata_ff <= '0;
      we_ff <= 1'b0;
      inc_ff <= 1'b0;
    end else begin
      we_ff <= (s_end && !dir_ff) || (p_wr && hi_ff);
      inc_ff <= s_end || p_word;
      if (s_dbit) begin
        rx_ff <= {rx_ff[DATA_W-2:0], sdi};
      end
      if (s_end) begin
        wdata_ff <= {rx_ff[DATA_W-2:0], sdi};
      end else if (p_wr && hi_ff) begin
        wdata_ff <= {b2_ff, lo_ff};
      end
    end
  end

  // Fetch after the address settles
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      fetch_ff <= 1'b0;
      hold_ff <= '0;
    end else begin
      fetch_ff <= s_fetch || inc_ff || p_addr;
      if (fetch_ff) begin
        hold_ff <= i_reg_rdata;
      end
    end
  end

  // Output shifter, loaded for reads and writes alike
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      tx_ff <= '0;
    end else if (!ser_act) begin
      tx_ff <= '0;
    end else if (s_rise) begin
      if (cnt_ff == CNT_W'(LOAD_EDGE)) begin
        tx_ff <= hold_ff;
      end else begin
        tx_ff <= {tx_ff[DATA_W-2:0], 1'b0};
      end
    end
  end

  // Parallel byte pairing: low byte first, then high byte
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      hi_ff <= 1'b0;
      lo_ff <= '0;
    end else if (p_addr) begin
      hi_ff <= 1'b0;
    end else if (p_wr || p_rd) begin
      hi_ff <= !hi_ff;
      if (p_wr && !hi_ff) begin
        lo_ff <= b2_ff;
      end
    end
  end

  // Pin data from a flip-flop; serial uses bus bit 0 only
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      out_ff <= '0;
    end else if (ser_act) begin
      out_ff <= {{(BUS_W-1){1'b0}}, tx_ff[DATA_W-1]};
    end else if (mode_ff == MODE_SER) begin
      // Idle serial output stays low so frame start moves no bit
      out_ff <= '0;
    end else if (hi_ff) begin
      out_ff <= hold_ff[DATA_W-1:BUS_W];
    end else begin
      out_ff <= hold_ff[BUS_W-1:0];
    end
  end

  assign link.dev_out = out_ff;
  assign link.dev_oe = ser_act ? BUS_W'(1) :
                       (p_drive ? '1 : '0);
  assign o_reg_addr = addr_ff;
  assign o_reg_wdata = wdata_ff;
  assign o_reg_we = we_ff;
  assign o_mode = mode_ff;
endmodule

// ---- rtl/hspp_host.sv ----
// Host end of the port: one-word serial frames (slow or fast sampling)
// and one-word transfers in parallel mode one.
// Assumes the device end is clocked at the same rate or faster.
`timescale 1ns/100ps
module hspp_host #(
  parameter int HALF_CYC = hspp_pkg::LINK_HALF_CYC, // Link half period
  parameter bit FAST = 1'b0 // Sample on rising edges, 25 clocks
) (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Asynchronous reset, high
  hspp_link_if.host link, // Device pins
  input wire logic [1:0] i_mode, // Mode to drive on select pins
  input wire logic i_req, // Start one word transfer
  input wire logic i_read, // 1 read, 0 write
  input wire logic [hspp_pkg::ADDR_W-1:0] i_addr, // Word address
  input wire logic [hspp_pkg::DATA_W-1:0] i_wdata, // Write data
  output logic o_busy, // Transfer in progress
  output logic o_done, // One-cycle end pulse
  output logic [hspp_pkg::DATA_W-1:0] o_rdata // Word read back
);
  import hspp_pkg::*;

  typedef enum logic [1:0] {H_IDLE, H_SER, H_END, H_PAR} hspp_hst_t;
  localparam int TMR_W = $clog2(HALF_CYC + 1);
  localparam logic [CNT_W-1:0] LAST = FAST ? CNT_W'(FAST_BITS) :
                                             CNT_W'(FRAME_BITS);

  hspp_hst_t st_ff;
  logic [TMR_W-1:0] tmr_ff;
  logic [CNT_W-1:0] n_ff;
  logic [FRAME_BITS-1:0] sh_ff;
  logic [DATA_W-1:0] rx_ff;
  logic [BUS_W-1:0] b1_ff;
  logic [BUS_W-1:0] b2_ff;
  logic [1:0] step_ff;
  logic [1:0] ph_ff;
  logic rd_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] wd_ff;
  logic cs_n_ff;
  logic sclk_ff;
  logic sdi_ff;
  logic ale_ff;
  logic pwr_n_ff;
  logic prd_n_ff;
  logic [BUS_W-1:0] pout_ff;
  logic poe_ff;
  logic [1:0] sel_ff;
  logic done_ff;

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      b1_ff <= '1;
      b2_ff <= '1;
    end else begin
      b1_ff <= link.bus;
      b2_ff <= b1_ff;
    end
  end

  wire tick = tmr_ff == '0;
  wire sdo = b2_ff[0];
  wire idle = st_ff == H_IDLE;
  wire go = idle && i_req && (i_mode == MODE_SER || i_mode == MODE_P1);
  wire [CNT_W-1:0] n_nx = n_ff + CNT_W'(1);
  wire slow_samp = !FAST && n_nx >= CNT_W'(SAMP_FIRST) &&
                   n_nx <= CNT_W'(FRAME_BITS);
  wire fast_samp = FAST && n_ff >= CNT_W'(SAMP_FIRST);
  wire p_last = ph_ff == 2'h2;
  wire p_rdstep = rd_ff && step_ff != 2'h0;
  wire [BUS_W-1:0] nxt_pout = step_ff == 2'h0 ? BUS_W'(addr_ff) :
                   (step_ff == 2'h1 ? wd_ff[BUS_W-1:0] :
                    wd_ff[DATA_W-1:BUS_W]);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      st_ff <= H_IDLE;
      tmr_ff <= '0;
      n_ff <= '0;
      sh_ff <= '0;
      rx_ff <= '0;
      step_ff <= '0;
      ph_ff <= '0;
      rd_ff <= 1'b0;
      addr_ff <= '0;
      wd_ff <= '0;
      cs_n_ff <= 1'b1;
      sclk_ff <= 1'b1;
      sdi_ff <= 1'b1;
      done_ff <= 1'b0;
      o_rdata <= '0;
    end else begin
      done_ff <= 1'b0;
      tmr_ff <= tick ? TMR_W'(HALF_CYC - 1) : tmr_ff - TMR_W'(1);
      case (st_ff)
        H_IDLE: begin
          tmr_ff <= TMR_W'(HALF_CYC - 1);
          if (go) begin
            cs_n_ff <= 1'b0;
            sh_ff <= {i_read, i_addr, i_wdata};
            sdi_ff <= i_read;
            n_ff <= '0;
            rd_ff <= i_read;
            addr_ff <= i_addr;
            wd_ff <= i_wdata;
            step_ff <= '0;
            ph_ff <= '0;
            st_ff <= i_mode == MODE_SER ? H_SER : H_PAR;
          end
        end
        H_SER: begin
          if (tick && sclk_ff) begin
            sclk_ff <= 1'b0;
            n_ff <= n_nx;
            if (slow_samp) begin
              rx_ff <= {rx_ff[DATA_W-2:0], sdo};
            end
          end else if (tick) begin
            sclk_ff <= 1'b1;
            sh_ff <= {sh_ff[FRAME_BITS-2:0], 1'b0};
            sdi_ff <= sh_ff[FRAME_BITS-2];
            if (fast_samp) begin
              rx_ff <= {rx_ff[DATA_W-2:0], sdo};
            end
            if (n_ff == LAST) begin
              st_ff <= H_END;
            end
          end
        end
        H_END: begin
          if (tick) begin
            cs_n_ff <= 1'b1;
            sdi_ff <= 1'b1;
            done_ff <= 1'b1;
            o_rdata <= FAST ? rx_ff : {rx_ff[DATA_W-2:0], sdo};
            st_ff <= H_IDLE;
          end
        end
        H_PAR: begin
          if (tick) begin
            ph_ff <= p_last ? 2'h0 : ph_ff + 2'h1;
            if (ph_ff == 2'h1 && p_rdstep) begin
              rx_ff <= {b2_ff, rx_ff[DATA_W-1:BUS_W]};
            end
            if (p_last && step_ff == 2'h2) begin
              cs_n_ff <= 1'b1;
              done_ff <= 1'b1;
              o_rdata <= rx_ff;
              st_ff <= H_IDLE;
            end else if (p_last) begin
              step_ff <= step_ff + 2'h1;
            end
          end
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  // Parallel pins registered one cycle after the phase decode
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      ale_ff <= 1'b0;
      pwr_n_ff <= 1'b1;
      prd_n_ff <= 1'b1;
      pout_ff <= '0;
      poe_ff <= 1'b0;
      sel_ff <= MODE_SER;
    end else begin
      if (idle) begin
        sel_ff <= i_mode;
      end
      ale_ff <= st_ff == H_PAR && step_ff == 2'h0;
      pwr_n_ff <= !(st_ff == H_PAR && ph_ff == 2'h1 && !p_rdstep);
      prd_n_ff <= !(st_ff == H_PAR && ph_ff == 2'h1 && p_rdstep);
      pout_ff <= nxt_pout;
      poe_ff <= st_ff == H_PAR && !p_rdstep;
    end
  end

  wire par_pins = sel_ff != MODE_SER;
  assign link.cs_n = cs_n_ff;
  assign link.wr_n = par_pins ? pwr_n_ff : sclk_ff;
  assign link.rd_n = par_pins ? prd_n_ff : sdi_ff;
  assign link.ale = ale_ff;
  // Mode pins follow i_mode while idle so they already stand in reset
  assign link.iface_sel_hi = idle ? i_mode[1] : sel_ff[1];
  assign link.iface_sel_lo = idle ? i_mode[0] : sel_ff[0];
  assign link.host_out = pout_ff;
  assign link.host_oe = poe_ff ? '1 : '0;
  assign o_busy = !idle;
  assign o_done = done_ff;
endmodule

// ---- sim/hspp_sva.sv ----
// Concurrent checks on the link between the host and device ends.
// Assumes both ends run from i_clk_sys and the device feeds a word map.
`timescale 1ns/100ps
module hspp_sva (
  input wire logic i_clk_sys, // System clock
  input wire logic i_rst, // Asynchronous reset, high
  input wire logic cs_n, // Frame sync or chip select
  input wire logic wr_n, // Link clock or write strobe
  input wire logic rd_n, // Serial data in or read strobe
  input wire logic iface_sel_hi, // Upper mode pin
  input wire logic iface_sel_lo, // Lower mode pin
  input wire logic [hspp_pkg::BUS_W-1:0] dev_out, // Device bus data
  input wire logic [hspp_pkg::BUS_W-1:0] dev_oe, // Device bus enables
  input wire logic o_reg_we, // Map write strobe
  input wire logic [hspp_pkg::ADDR_W-1:0] o_reg_addr, // Map address
  input wire logic [hspp_pkg::DATA_W-1:0] o_reg_wdata, // Map write data
  input wire logic [1:0] o_mode // Captured mode
);
  import hspp_pkg::*;
  logic wr_q_ff;
  logic dir_ff;
  logic [4:0] fall_cnt_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [DATA_W-1:0] data_ff;
  logic [3:0] rise_age_ff;
  logic [3:0] rel_cnt_ff;
  logic fall;
  logic rise;
  logic ser;
  assign fall = wr_q_ff & ~wr_n;
  assign rise = ~wr_q_ff & wr_n;
  assign ser = (o_mode == MODE_SER);

  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      wr_q_ff <= 1'b1;
      fall_cnt_ff <= 5'h00;
      rise_age_ff <= 4'hF;
      rel_cnt_ff <= 4'h0;
    end else begin
      wr_q_ff <= wr_n;
      fall_cnt_ff <= cs_n ? 5'h00 : fall_cnt_ff + {4'h0, fall};
      rise_age_ff <= rise ? 4'h0 : rise_age_ff + {3'h0, rise_age_ff != 4'hF};
      rel_cnt_ff <= rel_cnt_ff + {3'h0, rel_cnt_ff != 4'hF};
    end
  end

  // Shadow of the frame header and data as the device should see them
  always_ff @(posedge i_clk_sys) begin
    if (fall && fall_cnt_ff == 5'h00) dir_ff <= rd_n;
    if (fall && fall_cnt_ff inside {[5'h01:5'h07]})
      addr_ff <= {addr_ff[ADDR_W-2:0], rd_n};
    if (fall && fall_cnt_ff >= 5'h08)
      data_ff <= {data_ff[DATA_W-2:0], rd_n};
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  idle_release_a: assert property (cs_n [*4] |-> dev_oe == 8'h00)
    else $error("device drives the bus while deselected");
  serial_lane_a: assert property (ser |-> dev_oe[7:1] == 7'h00)
    else $error("serial mode drives more than bit zero");
  write_count_a: assert property (ser && o_reg_we |-> fall_cnt_ff == 5'h18)
    else $error("serial write strobe not at falling edge 24");
  write_dir_a: assert property (ser && o_reg_we |-> !dir_ff)
    else $error("write strobe in a read frame");
  write_addr_a: assert property (ser && o_reg_we |-> o_reg_addr == addr_ff)
    else $error("serial write to wrong address");
  write_data_a: assert property (ser && o_reg_we |-> o_reg_wdata == data_ff)
    else $error("serial write with wrong data");
  strobe_pulse_a: assert property (o_reg_we |=> !o_reg_we)
    else $error("write strobe longer than one cycle");
  out_edge_a: assert property (ser && !cs_n && $changed(dev_out[0]) |->
    rise_age_ff inside {[4'h1:4'h7]})
    else $error("serial output moved away from a rising edge");
  par_drive_a: assert property ((o_mode == MODE_P1 && !cs_n && !rd_n) [*5]
    |-> dev_oe == 8'hFF)
    else $error("read strobe does not drive the whole bus");
  par_quiet_a: assert property ((o_mode == MODE_P1 && rd_n) [*4]
    |-> dev_oe == 8'h00)
    else $error("bus driven without a read strobe");
  mode_pins_a: assert property (rel_cnt_ff == 4'hF |->
    o_mode == {iface_sel_hi, iface_sel_lo})
    else $error("captured mode differs from the mode pins");
  mode_hold_a: assert property (rel_cnt_ff == 4'hF |-> $stable(o_mode))
    else $error("mode changed outside reset");

  cover property (ser && o_reg_we);
  cover property (ser && dir_ff && fall_cnt_ff == 5'h18);
  cover property (o_mode == MODE_P1 && dev_oe == 8'hFF);
  cover property (o_mode == MODE_P3);
endmodule

// ---- sim/host_serial_parallel_port_bench.sv ----
// Bench: host and device ends on one link, and a second device end
// clocked by hand for continuous and cut-short frames.
// Assumes a 100 MHz system clock and a combinational word map.
`timescale 1ns/100ps
module host_serial_parallel_port_bench;
  import hspp_pkg::*;
  localparam int H = LINK_HALF_CYC;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic [1:0] h_mode = MODE_SER;
  logic h_req = 1'b0;
  logic h_read = 1'b0;
  logic [ADDR_W-1:0] h_addr = 7'h00;
  logic [DATA_W-1:0] h_wdata = 16'h0000;
  logic h_busy, h_done, a_we, b_we;
  logic [DATA_W-1:0] h_rdata, a_wdata, b_wdata;
  logic [ADDR_W-1:0] a_addr, b_addr;
  logic [1:0] a_mode, b_mode;
  logic [DATA_W-1:0] regs [128];
  logic [22:0] b_log [$];
  int fails = 0;
  int checks = 0;
  hspp_link_if link ();
  hspp_link_if link_b ();

  hspp_dev i_hspp_dev (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .link(link.dev), .o_reg_addr(a_addr), .o_reg_wdata(a_wdata),
    .o_reg_we(a_we), .i_reg_rdata(regs[a_addr]), .o_mode(a_mode));
  hspp_dev i_hspp_dev_b (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .link(link_b.dev), .o_reg_addr(b_addr), .o_reg_wdata(b_wdata),
    .o_reg_we(b_we), .i_reg_rdata({9'h000, b_addr} ^ 16'hC300),
    .o_mode(b_mode));
  hspp_host i_hspp_host (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .link(link.host), .i_mode(h_mode), .i_req(h_req), .i_read(h_read),
    .i_addr(h_addr), .i_wdata(h_wdata), .o_busy(h_busy),
    .o_done(h_done), .o_rdata(h_rdata));
  hspp_sva i_hspp_sva (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .cs_n(link.cs_n), .wr_n(link.wr_n), .rd_n(link.rd_n),
    .iface_sel_hi(link.iface_sel_hi), .iface_sel_lo(link.iface_sel_lo),
    .dev_out(link.dev_out), .dev_oe(link.dev_oe), .o_reg_we(a_we),
    .o_reg_addr(a_addr), .o_reg_wdata(a_wdata), .o_mode(a_mode));

  initial begin
    forever #(SYS_NS / 2) i_clk_sys = ~i_clk_sys;
  end

  always @(posedge i_clk_sys) if (a_we) regs[a_addr] <= a_wdata;
  always @(posedge i_clk_sys) if (b_we) b_log.push_back({b_addr, b_wdata});

  task automatic check(input logic [15:0] got, input logic [15:0] exp,
                       input string msg);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t ns: %s", $time, msg);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic do_reset(input logic [1:0] mode);
    @(negedge i_clk_sys);
    i_rst = 1'b1;
    h_mode = mode;
    repeat (6) @(negedge i_clk_sys);
    i_rst = 1'b0;
    repeat (6) @(negedge i_clk_sys);
  endtask

  // One word through the host end, then time for the device to settle
  task automatic xfer(input logic rd, input logic [6:0] ad,
                      input logic [15:0] wd);
    int n;
    @(negedge i_clk_sys);
    h_read = rd;
    h_addr = ad;
    h_wdata = wd;
    h_req = 1'b1;
    @(negedge i_clk_sys);
    h_req = 1'b0;
    n = 0;
    while (h_done !== 1'b1 && n < 2000) begin
      @(negedge i_clk_sys);
      n++;
    end
    check({15'h0000, h_done}, 16'h0001, "transfer did not end");
    repeat (H) @(negedge i_clk_sys);
  endtask

  // Hand-made link clock; output bit taken just before each fall
  task automatic b_bits(input logic [39:0] v, input int n,
                        output logic [39:0] got);
    got = '0;
    for (int i = 0; i < n; i++) begin
      link_b.rd_n = v[39-i];
      repeat (H) @(negedge i_clk_sys);
      got[39-i] = link_b.bus[0];
      link_b.wr_n = 1'b0;
      repeat (H) @(negedge i_clk_sys);
      link_b.wr_n = 1'b1;
    end
  endtask

  task automatic t_serial();
    do_reset(MODE_SER);
    check({14'h0000, a_mode}, 16'h0000, "serial mode");
    xfer(1'b0, 7'h7F, 16'hA5C3);
    check(regs[7'h7F], 16'hA5C3, "serial write");
    xfer(1'b1, 7'h2A, 16'h0000);
    check(h_rdata, 16'h0F2A, "serial read of preset word");
    xfer(1'b1, 7'h7F, 16'h0000);
    check(h_rdata, 16'hA5C3, "serial read after write");
    $display("test serial done");
  endtask

  task automatic t_link_b();
    logic [39:0] got;
    link_b.cs_n = 1'b0;
    repeat (H) @(negedge i_clk_sys);
    b_bits({1'b0, 7'h7F, 16'h1111, 16'h2222}, 40, got);
    link_b.cs_n = 1'b1;
    check(got[30:15], 16'hC37F, "word sent during write");
    b_bits(40'h00_0000_0000, 4, got);
    link_b.cs_n = 1'b0;
    repeat (H) @(negedge i_clk_sys);
    b_bits({1'b0, 7'h10, 16'hFFFF, 16'h0000}, 20, got);
    link_b.cs_n = 1'b1;
    repeat (H) @(negedge i_clk_sys);
    check(16'(b_log.size()), 16'h0002, "count of link b writes");
    check({9'h000, b_log[0][22:16]}, 16'h007F, "first address");
    check(b_log[0][15:0], 16'h1111, "first word");
    check({9'h000, b_log[1][22:16]}, 16'h0000, "address wrap");
    check(b_log[1][15:0], 16'h2222, "continued word");
    $display("test continuous and cut frames done");
  endtask

  task automatic t_par1();
    do_reset(MODE_P1);
    check({14'h0000, a_mode}, 16'h0001, "parallel mode one");
    xfer(1'b0, 7'h05, 16'h1234);
    check(regs[7'h05], 16'h1234, "parallel write");
    check({9'h000, a_addr}, 16'h0006, "pointer after write");
    xfer(1'b1, 7'h05, 16'h0000);
    check(h_rdata, 16'h1234, "parallel read");
    $display("test parallel mode one done");
  endtask

  task automatic t_modes();
    for (int m = 2; m < 4; m++) begin
      do_reset(m[1:0]);
      check({14'h0000, a_mode}, m[15:0], "upper parallel mode");
      h_req = 1'b1;
      repeat (3) @(negedge i_clk_sys);
      check({15'h0000, h_busy}, 16'h0000, "host idle in mode");
      h_req = 1'b0;
    end
    $display("test mode pins done");
  endtask

  initial begin
    link_b.cs_n = 1'b1;
    link_b.wr_n = 1'b1;
    link_b.rd_n = 1'b1;
    link_b.ale = 1'b0;
    link_b.iface_sel_hi = 1'b0;
    link_b.iface_sel_lo = 1'b0;
    link_b.host_out = 8'h00;
    link_b.host_oe = 8'h00;
    for (int i = 0; i < 128; i++) regs[i] = 16'h0F00 ^ i[15:0];
    t_serial();
    t_link_b();
    t_par1();
    t_modes();
    report_and_stop();
  end

  initial begin
    #200000;
    fails++;
    $display("wrong value at %0t ns: watchdog expired", $time);
    report_and_stop();
  end
endmodule
